// *** design/fwp_defs.svh ***
/*
   Offsets, reset values, command codes and array geometry of the flash write-protect block.
   Assumes inclusion by bare name from any design file that needs these constants.
*/
`ifndef FWP_DEFS_SVH
`define FWP_DEFS_SVH

// Register byte offsets on the Wishbone slave.
`define FWP_OFF_STATUS   8'h00
`define FWP_OFF_CMD      8'h04
`define FWP_OFF_PE_START 8'h08
`define FWP_OFF_PE_END   8'h0C
`define FWP_OFF_RESULT   8'h10
`define FWP_OFF_PROT_LO  8'h14
`define FWP_OFF_PROT_HI  8'h18

// Field positions and reset values.
`define FWP_STATUS_RESET 8'h00
`define FWP_STATUS_LSB   0
`define FWP_WEL_BIT      8
`define FWP_WP_BIT       9
`define FWP_NONE_BIT     24
`define FWP_OP_LSB       0

// Command codes written to the command register.
`define FWP_OP_WREN      3'h1
`define FWP_OP_WRDI      3'h2
`define FWP_OP_PWRCYC    3'h3

// Lock settings as {status_lock_upper, status_lock_lower}.
`define FWP_LOCK_SOFT    2'h0
`define FWP_LOCK_HW      2'h1
`define FWP_LOCK_DOWN    2'h2
`define FWP_LOCK_OTP     2'h3

// Array geometry, 512 kB.
`define FWP_ARRAY_TOP    19'h7_FFFF
`define FWP_ARRAY_SIZE   20'h8_0000
`define FWP_SZ_4K        19'h0_1000
`define FWP_SZ_32K       19'h0_8000
`define FWP_SZ_64K       19'h1_0000

`endif

// *** design/fwp_pkg.sv ***
/*
   Types shared by the flash write-protect block.
   Assumes nothing of its surroundings.
*/
`default_nettype none

package fwp_pkg;

   typedef logic [18:0] flash_addr_t;

   typedef struct packed {
      logic       lock_upper;
      logic       lock_lower;
      logic       complement_protect;
      logic [4:0] block_protect_field;
   } status_s;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_ACK  = 2'b01
   } bus_state_e;

endpackage

`default_nettype wire

// *** design/prot_range_if.sv ***
/*
   Carrier between the protect-field owner and the range decoder.
   Assumes the owner drives the protect bits and the decoder drives the range.
*/
`default_nettype none

interface prot_range_if;
   logic [4:0]          block_protect_field;
   logic                complement_protect;
   logic                none;
   fwp_pkg::flash_addr_t lo;
   fwp_pkg::flash_addr_t hi;

   modport dec  (input block_protect_field, input complement_protect, output none, output lo, output hi);
   modport user (output block_protect_field, output complement_protect, input none, input lo, input hi);
endinterface

`default_nettype wire

// *** design/prot_range_decode.sv ***
/*
   Decodes the block-protect field and complement bit into one protected address range.
   Assumes a 512 kB array; purely combinational, fed from registered status bits.
*/
`default_nettype none
`include "fwp_defs.svh"

module prot_range_decode (
   prot_range_if.dec pr
);
   wire [4:0]            bp = pr.block_protect_field;
   wire                  cmp = pr.complement_protect;
   wire                  base_none;
   wire                  base_all;
   wire                  bottom;
   fwp_pkg::flash_addr_t coarse_sz;
   fwp_pkg::flash_addr_t fine_sz;
   fwp_pkg::flash_addr_t sz;
   fwp_pkg::flash_addr_t top_lo;

   // Low bits 000 protect nothing, in both coarse and fine modes.
   assign base_none = (bp[2:0] == 3'h0);
   assign base_all  = bp[4] ? (bp[2:0] == 3'h7) : bp[2];
   assign bottom    = bp[3];
   assign coarse_sz = `FWP_SZ_64K << (2'(bp[1:0] - 2'h1));
   assign fine_sz   = bp[2] ? `FWP_SZ_32K : (`FWP_SZ_4K << (2'(bp[1:0] - 2'h1)));
   assign sz        = bp[4] ? fine_sz : coarse_sz;
   assign top_lo    = 19'(`FWP_ARRAY_SIZE - {1'b0, sz});

   // The complement swaps all and none and flips a partial range about its boundary.
   assign pr.none = cmp ? base_all : base_none;
   assign pr.lo   = (cmp ? base_none : base_all) ? 19'h0 :
                    (cmp ? (bottom ? sz : 19'h0) : (bottom ? 19'h0 : top_lo));
   assign pr.hi   = (cmp ? base_none : base_all) ? `FWP_ARRAY_TOP :
                    (cmp ? (bottom ? `FWP_ARRAY_TOP : 19'(top_lo - 19'h1)) :
                           (bottom ? 19'(sz - 19'h1) : `FWP_ARRAY_TOP));
endmodule

`default_nettype wire

// *** design/flash_write_protect_decode.sv ***
/*
   Write-protection logic of a serial NOR flash behind a classic Wishbone slave.
   Assumes a single 200 MHz clock, a synchronous active-high reset that stands for delivery
   state, and an asynchronous write-protect pin that is synchronised here.
*/
// Behaviour
// - Locks 00: status write accepted whenever the write enable latch is set.
// - Locks 01 with protect pin low: every status write is refused.
// - Locks 01 with protect pin high: status write accepted with latch set.
// - Locks 10: status writes refused until a power cycle.
// - A power cycle turns locks 10 into 00.
// - Locks 11: status register can never be written again.
// - Delivered with locks 00, software protected.
// - Complement 0, coarse field decodes top 64, 128, 256 kB, none or all.
// - Complement 0, coarse with second bit set protects the bottom instead.
// - Complement 0, fine mode protects 4 to 32 kB at top or bottom.
// - Complement 1 protects the complement of the coarse region.
// - Complement 1, fine mode protects all but the small region.
// - Program or erase touching any protected address is ignored.
// - Latch clear refuses status writes, programs and erases.
// - Protect bits change only by an allowed status write.
`default_nettype none
`include "fwp_defs.svh"

module flash_write_protect_decode (
   // Clock and reset.
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Wishbone slave.
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   // Write-protect pin, low protects.
   input  wire logic        wp_pin_i,
   // Accepted program or erase towards the array.
   output logic             pe_go_o,
   output logic [18:0]      pe_start_o,
   output logic [18:0]      pe_end_o
);

   fwp_pkg::bus_state_e  st_q;
   fwp_pkg::bus_state_e  st_d;
   fwp_pkg::status_s     stat_q;
   fwp_pkg::status_s     stat_d;
   logic                 wel_q;
   logic                 wel_d;
   logic                 wp_s1_q;
   logic                 wp_s2_q;
   fwp_pkg::flash_addr_t pe_start_q;
   fwp_pkg::flash_addr_t pe_start_d;
   fwp_pkg::flash_addr_t pe_end_q;
   fwp_pkg::flash_addr_t pe_end_d;
   logic                 pe_go_q;
   logic [3:0]           res_q;
   logic [3:0]           res_d;
   logic [31:0]          rdata_q;

   wire                  bus_req;
   wire                  bus_take;
   wire                  bus_wr;
   wire [1:0]            lock;
   wire [2:0]            op;
   wire                  sw_req;
   wire                  cmd_req;
   wire                  wren_req;
   wire                  wrdi_req;
   wire                  pc_req;
   wire                  start_wr;
   wire                  pe_req;
   wire                  sw_allowed;
   wire                  sw_ok;
   wire                  pe_hit;
   wire                  pe_ok;
   fwp_pkg::flash_addr_t pe_end_w;
   fwp_pkg::status_s     stat_pc;
   logic [31:0]          rd_mux;

   prot_range_if pr_if ();

   // Returns true when the span s..e shares any address with the protected lo..hi.
   function automatic logic hits(input fwp_pkg::flash_addr_t s, input fwp_pkg::flash_addr_t e,
                                 input fwp_pkg::flash_addr_t lo, input fwp_pkg::flash_addr_t hi,
                                 input logic none);
      hits = !none && (s <= hi) && (e >= lo);
   endfunction

   // Byte-lane merge for address registers written over the bus.
   function automatic fwp_pkg::flash_addr_t merge(input fwp_pkg::flash_addr_t old,
                                                  input logic [31:0] din, input logic [3:0] sel);
      logic [31:0] w;
      w = {13'h0, old};
      for (int i = 0; i < 3; i++) begin
         if (sel[i]) begin
            w[i*8 +: 8] = din[i*8 +: 8];
         end
      end
      merge = w[18:0];
   endfunction

   assign pr_if.block_protect_field = stat_q.block_protect_field;
   assign pr_if.complement_protect  = stat_q.complement_protect;

   prot_range_decode u_dec (
      .pr (pr_if.dec)
   );

   // Bus handshake: ack one cycle after the request, effects at the ack edge.
   assign bus_req  = wb_cyc_i & wb_stb_i;
   assign bus_take = bus_req & (st_q == fwp_pkg::BUS_ACK);
   assign bus_wr   = bus_take & wb_we_i;
   assign wb_ack_o = (st_q == fwp_pkg::BUS_ACK);
   assign wb_dat_o = rdata_q;

   always_comb begin
      case (st_q)
         fwp_pkg::BUS_IDLE: st_d = bus_req ? fwp_pkg::BUS_ACK : fwp_pkg::BUS_IDLE;
         fwp_pkg::BUS_ACK:  st_d = fwp_pkg::BUS_IDLE;
         default:           st_d = fwp_pkg::BUS_IDLE;
      endcase
   end

   // Request decode.
   assign lock     = {stat_q.lock_upper, stat_q.lock_lower};
   assign op       = wb_dat_i[`FWP_OP_LSB +: 3];
   assign sw_req   = bus_wr & (wb_adr_i == `FWP_OFF_STATUS) & wb_sel_i[0];
   assign cmd_req  = bus_wr & (wb_adr_i == `FWP_OFF_CMD) & wb_sel_i[0];
   assign wren_req = cmd_req & (op == `FWP_OP_WREN);
   assign wrdi_req = cmd_req & (op == `FWP_OP_WRDI);
   assign pc_req   = cmd_req & (op == `FWP_OP_PWRCYC);
   assign start_wr = bus_wr & (wb_adr_i == `FWP_OFF_PE_START);
   assign pe_req   = bus_wr & (wb_adr_i == `FWP_OFF_PE_END);

   // Lock-down and one-time settings never open; the pin only matters in the hardware setting.
   assign sw_allowed = wel_q & ((lock == `FWP_LOCK_SOFT) |
                                ((lock == `FWP_LOCK_HW) & wp_s2_q));
   assign sw_ok      = sw_req & sw_allowed;

   // A power cycle releases only the lock-down setting; the other bits are non-volatile.
   assign stat_pc = (lock == `FWP_LOCK_DOWN) ?
                    fwp_pkg::status_s'({2'b00, stat_q[5:0]}) : stat_q;

   // Program and erase check against the whole range; a reversed span is refused as well.
   assign pe_end_w = merge(pe_end_q, wb_dat_i, wb_sel_i);
   assign pe_hit   = hits(pe_start_q, pe_end_w, pr_if.lo, pr_if.hi, pr_if.none);
   assign pe_ok    = pe_req & wel_q & (pe_start_q <= pe_end_w) & !pe_hit;

   assign stat_d     = sw_ok ? fwp_pkg::status_s'(wb_dat_i[`FWP_STATUS_LSB +: 8]) :
                       (pc_req ? stat_pc : stat_q);
   assign wel_d      = wren_req ? 1'b1 :
                       ((wrdi_req | pc_req | sw_ok | pe_ok) ? 1'b0 : wel_q);
   assign pe_start_d = start_wr ? merge(pe_start_q, wb_dat_i, wb_sel_i) : pe_start_q;
   assign pe_end_d   = pe_req ? pe_end_w : pe_end_q;
   assign res_d      = sw_req ? {2'b00, !sw_ok, sw_ok} :
                       (pe_req ? {!pe_ok, pe_ok, 2'b00} : res_q);

   always_comb begin
      case (wb_adr_i)
         `FWP_OFF_STATUS:   rd_mux = {22'h0, wp_s2_q, wel_q, stat_q};
         `FWP_OFF_PE_START: rd_mux = {13'h0, pe_start_q};
         `FWP_OFF_PE_END:   rd_mux = {13'h0, pe_end_q};
         `FWP_OFF_RESULT:   rd_mux = {28'h0, res_q};
         `FWP_OFF_PROT_LO:  rd_mux = {7'h0, pr_if.none, 5'h0, pr_if.lo};
         `FWP_OFF_PROT_HI:  rd_mux = {13'h0, pr_if.hi};
         default:           rd_mux = 32'h0000_0000;
      endcase
   end

   // The first stage of the pin synchroniser feeds only the second.
   always_ff @(posedge clk_i) begin
      wp_s1_q <= wp_pin_i;
      wp_s2_q <= wp_s1_q;
   end

   // Reset stands for the delivered state with software protection.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_q       <= fwp_pkg::BUS_IDLE;
         stat_q     <= fwp_pkg::status_s'(`FWP_STATUS_RESET);
         wel_q      <= 1'b0;
         pe_start_q <= 19'h0;
         pe_end_q   <= 19'h0;
         pe_go_q    <= 1'b0;
         res_q      <= 4'h0;
         rdata_q    <= 32'h0000_0000;
      end else begin
         st_q       <= st_d;
         stat_q     <= stat_d;
         wel_q      <= wel_d;
         pe_start_q <= pe_start_d;
         pe_end_q   <= pe_end_d;
         pe_go_q    <= pe_ok;
         res_q      <= res_d;
         rdata_q    <= (bus_req & (st_q == fwp_pkg::BUS_IDLE)) ? rd_mux : rdata_q;
      end
   end

   assign pe_go_o    = pe_go_q;
   assign pe_start_o = pe_start_q;
   assign pe_end_o   = pe_end_q;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   a_wel_gates_status: assert property (sw_req && !wel_q |=> stat_q == $past(stat_q))
      else $error("status changed without write enable latch");

   a_hw_lock_holds: assert property (sw_req && lock == `FWP_LOCK_HW && !wp_s2_q
                                     |=> $stable(stat_q))
      else $error("status written while hardware protected");

   a_hw_unlock_write: assert property (sw_req && wel_q && lock == `FWP_LOCK_HW && wp_s2_q
                                       |=> stat_q == $past(wb_dat_i[7:0]) && !wel_q)
      else $error("status write refused while hardware unprotected");

   a_soft_write: assert property (sw_req && wel_q && lock == `FWP_LOCK_SOFT
                                  |=> stat_q == $past(wb_dat_i[7:0]) ##1 res_q[0])
      else $error("status write refused while software protected");

   a_lockdown_holds: assert property (lock == `FWP_LOCK_DOWN && !pc_req
                                      |=> {stat_q.lock_upper, stat_q.lock_lower} == `FWP_LOCK_DOWN)
      else $error("lock-down left without a power cycle");

   a_otp_forever: assert property (lock == `FWP_LOCK_OTP
                                   |=> {stat_q.lock_upper, stat_q.lock_lower} == `FWP_LOCK_OTP)
      else $error("one-time lock changed");

   a_power_cycle: assert property (pc_req && lock == `FWP_LOCK_DOWN
                                   |=> lock == `FWP_LOCK_SOFT && !wel_q && $stable(stat_q[5:0]))
      else $error("power cycle did not release lock-down");

   a_delivered: assert property ($fell(rst_i) |-> lock == `FWP_LOCK_SOFT && !wel_q)
      else $error("delivered lock setting wrong");

   a_pe_blocked: assert property (pe_req && hits(pe_start_q, pe_end_w, pr_if.lo, pr_if.hi,
                                                 pr_if.none) |=> !pe_go_o ##1 !pe_go_o)
      else $error("program or erase issued into protected range");

   a_pe_issued: assert property (pe_ok |=> pe_go_o && pe_end_o == $past(pe_end_w) ##1 !pe_go_o)
      else $error("accepted program or erase not issued once");

   a_pe_needs_wel: assert property (pe_req && !wel_q |=> !pe_go_o && res_q == 4'h8)
      else $error("program or erase without write enable latch");

   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");

   a_ack_answers: assert property (bus_req && !wb_ack_o |=> wb_ack_o)
      else $error("request not answered");

   // Short names for the protect bits, read only by the checks below.
   wire [4:0]            prot_bits;
   wire                  prot_cmp;
   wire                  prot_full;
   wire                  prot_part;

   assign prot_bits = stat_q.block_protect_field;
   assign prot_cmp  = stat_q.complement_protect;
   assign prot_full = prot_bits[4] ? (prot_bits[2:0] == 3'h7) : prot_bits[2];
   assign prot_part = (prot_bits[2:0] != 3'h0) && !prot_full;

   // Status write outcome for every lock setting.
   a_soft_any_pin: assert property (sw_req && wel_q && lock == `FWP_LOCK_SOFT && !wp_s2_q
                                    |=> stat_q == $past(wb_dat_i[7:0]))
      else $error("soft write refused with pin low");

   a_soft_result: assert property (sw_req && wel_q && lock == `FWP_LOCK_SOFT |=> res_q == 4'h1)
      else $error("soft write not reported");

   a_hw_result: assert property (sw_req && lock == `FWP_LOCK_HW && !wp_s2_q |=> res_q == 4'h2)
      else $error("hardware refusal not reported");

   a_hw_keeps_wel: assert property (sw_req && wel_q && lock == `FWP_LOCK_HW && !wp_s2_q |=> wel_q)
      else $error("refused write cleared latch");

   a_unlock_result: assert property (sw_req && wel_q && lock == `FWP_LOCK_HW && wp_s2_q
                                     |=> res_q == 4'h1)
      else $error("unprotected write not reported");

   a_down_refused: assert property (sw_req && lock == `FWP_LOCK_DOWN
                                    |=> $stable(stat_q) && res_q == 4'h2)
      else $error("status written in lock-down");

   a_sw_clears_wel: assert property (sw_ok |=> !wel_q)
      else $error("accepted write kept latch");

   a_pc_other_keep: assert property (pc_req && lock != `FWP_LOCK_DOWN |=> $stable(stat_q))
      else $error("power cycle changed other bits");

   a_pc_clears_wel: assert property (pc_req |=> !wel_q)
      else $error("power cycle kept latch");

   a_otp_refused: assert property (sw_req && lock == `FWP_LOCK_OTP
                                   |=> $stable(stat_q) && res_q == 4'h2)
      else $error("status written after one-time lock");

   a_delivered_bits: assert property ($fell(rst_i) |-> stat_q == `FWP_STATUS_RESET && res_q == 4'h0)
      else $error("delivered bits wrong");

   // Decoded range for each class of protect setting.
   a_none_decode: assert property (!prot_cmp && prot_bits[2:0] == 3'h0 |-> pr_if.none)
      else $error("empty field decoded as range");

   a_full_decode: assert property (!prot_cmp && prot_full
                                   |-> !pr_if.none && pr_if.lo == 19'h0 && pr_if.hi == `FWP_ARRAY_TOP)
      else $error("whole array decoded wrong");

   a_coarse_top: assert property (!prot_cmp && prot_bits[4:3] == 2'b00 && prot_part
                                  |-> pr_if.hi == `FWP_ARRAY_TOP && pr_if.lo[15:0] == 16'h0000)
      else $error("upper coarse range wrong");

   a_coarse_bottom: assert property (!prot_cmp && prot_bits[4:3] == 2'b01 && prot_part
                                     |-> pr_if.lo == 19'h0 && pr_if.hi[15:0] == 16'hFFFF)
      else $error("lower coarse range wrong");

   a_fine_small: assert property (!prot_cmp && prot_bits[4] && prot_part
                                  |-> !pr_if.none && 19'(pr_if.hi - pr_if.lo) < `FWP_SZ_32K)
      else $error("fine range too large");

   a_cmp_all: assert property (prot_cmp && prot_bits[2:0] == 3'h0
                               |-> !pr_if.none && pr_if.lo == 19'h0 && pr_if.hi == `FWP_ARRAY_TOP)
      else $error("complemented empty field wrong");

   a_cmp_none: assert property (prot_cmp && prot_full |-> pr_if.none)
      else $error("complemented full field wrong");

   a_cmp_one_end: assert property (prot_cmp && prot_part
                                   |-> !pr_if.none && ((pr_if.lo == 19'h0) != (pr_if.hi == `FWP_ARRAY_TOP)))
      else $error("complemented range not at one end");

   // Program, erase and latch handling.
   a_pe_accept_result: assert property (pe_ok |=> !wel_q && res_q == 4'h4)
      else $error("accepted span not reported");

   a_pe_refuse_keeps: assert property (pe_req && !pe_ok |=> res_q == 4'h8 && wel_q == $past(wel_q))
      else $error("refused span changed latch");

   a_go_outside_prot: assert property (pe_go_o
                                       |-> !hits(pe_start_o, pe_end_o, pr_if.lo, pr_if.hi, pr_if.none))
      else $error("issued span overlaps protection");

   a_wren_sets: assert property (wren_req |=> wel_q)
      else $error("write enable did not set latch");

   a_wrdi_clears: assert property (wrdi_req |=> !wel_q)
      else $error("write disable did not clear latch");

   a_bits_by_write: assert property (!sw_ok
                                     |=> prot_bits == $past(prot_bits) && prot_cmp == $past(prot_cmp))
      else $error("protect bits changed without write");

endmodule

`default_nettype wire

// *** sim/pe_array_model.sv ***
/*
   Model of the array side: counts accepted program or erase pulses and keeps the last span.
   Assumes the pulse and span outputs of the write-protect block, on the same clock.
*/
`default_nettype none

module pe_array_model (
   // Clock and reset.
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Accepted operation from the protect logic.
   input  wire logic        pe_go_i,
   input  wire logic [18:0] pe_start_i,
   input  wire logic [18:0] pe_end_i
);
   timeunit 1ns;
   timeprecision 100ps;

   int          ops;
   logic [18:0] last_start;
   logic [18:0] last_end;

   // Only spans that passed the protection check may reach the array, so each pulse is counted.
   always @(posedge clk_i) begin
      if (rst_i) begin
         ops <= 0;
      end else if (pe_go_i === 1'b1) begin
         ops        <= ops + 1;
         last_start <= pe_start_i;
         last_end   <= pe_end_i;
      end
   end
endmodule

`default_nettype wire

// *** sim/tb.sv ***
/*
   Self-checking bench for the flash write-protect block, driven over Wishbone.
   Assumes the block's register map; the bus answer latency is not assumed.
*/
`default_nettype none
`include "fwp_defs.svh"

module tb;
   timeunit 1ns;
   timeprecision 100ps;

   logic        clk_i;
   logic        rst_i;
   logic        cyc;
   logic        stb;
   logic        we;
   logic [7:0]  adr;
   logic [3:0]  sel;
   logic [31:0] dat;
   logic [31:0] rdat;
   logic        ack;
   logic        wp_pin;
   logic        pe_go;
   logic [18:0] pe_start;
   logic [18:0] pe_end;
   int          mismatches;
   int          num_checks;
   // Status byte, none flag, low and high address of the expected protected range.
   logic [46:0] tab [19] = '{
      {8'h01, 1'b0, 19'h7_0000, 19'h7_FFFF}, {8'h02, 1'b0, 19'h6_0000, 19'h7_FFFF},
      {8'h03, 1'b0, 19'h4_0000, 19'h7_FFFF}, {8'h09, 1'b0, 19'h0_0000, 19'h0_FFFF},
      {8'h0A, 1'b0, 19'h0_0000, 19'h1_FFFF}, {8'h0B, 1'b0, 19'h0_0000, 19'h3_FFFF},
      {8'h04, 1'b0, 19'h0_0000, 19'h7_FFFF}, {8'h11, 1'b0, 19'h7_F000, 19'h7_FFFF},
      {8'h16, 1'b0, 19'h7_8000, 19'h7_FFFF}, {8'h19, 1'b0, 19'h0_0000, 19'h0_0FFF},
      {8'h1F, 1'b0, 19'h0_0000, 19'h7_FFFF}, {8'h18, 1'b1, 19'h0_0000, 19'h0_0000},
      {8'h20, 1'b0, 19'h0_0000, 19'h7_FFFF}, {8'h21, 1'b0, 19'h0_0000, 19'h6_FFFF},
      {8'h29, 1'b0, 19'h1_0000, 19'h7_FFFF}, {8'h24, 1'b1, 19'h0_0000, 19'h0_0000},
      {8'h31, 1'b0, 19'h0_0000, 19'h7_EFFF}, {8'h3C, 1'b0, 19'h0_8000, 19'h7_FFFF},
      {8'h3F, 1'b1, 19'h0_0000, 19'h0_0000}};

   flash_write_protect_decode u_dut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .wp_pin_i(wp_pin),
      .pe_go_o(pe_go), .pe_start_o(pe_start), .pe_end_o(pe_end));

   pe_array_model u_array (
      .clk_i(clk_i), .rst_i(rst_i), .pe_go_i(pe_go), .pe_start_i(pe_start), .pe_end_i(pe_end));

   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end

   // The whole sequence needs about 450 cycles; over ten times that means a hang.
   initial begin
      repeat (5000) @(posedge clk_i);
      mismatches++;
      test_done();
   end

   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] mask);
      num_checks++;
      if ((got & mask) !== (exp & mask)) begin
         mismatches++;
         $display("unexpected at %0t: got %h expected %h", $time, got & mask, exp & mask);
      end
   endtask

   // Holds the request until ack is sampled high; read data is taken at that same edge.
   task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= a;
      dat <= d;
      sel <= 4'hF;
      // Only a high ack ends this wait, or the watchdog if ack never comes.
      do begin
         @(posedge clk_i);
      end while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb_cycle(1'b1, a, d, q);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] mask);
      logic [31:0] q;
      wb_cycle(1'b0, a, 32'h0000_0000, q);
      check(q, exp, mask);
   endtask

   task automatic wr_status(input logic [7:0] v);
      wr(`FWP_OFF_CMD, {29'h0, `FWP_OP_WREN});
      wr(`FWP_OFF_STATUS, {24'h0, v});
   endtask

   initial begin
      rst_i = 1'b1;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 8'h00;
      sel = 4'h0;
      dat = 32'h0000_0000;
      wp_pin = 1'b0;
      mismatches = 0;
      num_checks = 0;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      rd_chk(`FWP_OFF_STATUS, 32'h0000_0000, 32'hFFFF_FFFF);
      wr(`FWP_OFF_STATUS, 32'h0000_0001);
      rd_chk(`FWP_OFF_STATUS, 32'h0000_0000, 32'hFFFF_FFFF);
      rd_chk(`FWP_OFF_RESULT, 32'h0000_0002, 32'h0000_000F);
      wr(`FWP_OFF_CMD, {29'h0, `FWP_OP_WREN});
      rd_chk(`FWP_OFF_STATUS, 32'h0000_0100, 32'hFFFF_FFFF);
      wr(`FWP_OFF_CMD, {29'h0, `FWP_OP_WRDI});
      wr(`FWP_OFF_STATUS, 32'h0000_0001);
      rd_chk(`FWP_OFF_STATUS, 32'h0000_0000, 32'hFFFF_FFFF);
      // Every table row is written with the pin low, which software protection ignores.
      foreach (tab[i]) begin
         wr_status(tab[i][46:39]);
         rd_chk(`FWP_OFF_STATUS, {24'h0, tab[i][46:39]}, 32'h0000_00FF);
         if (tab[i][38]) begin
            rd_chk(`FWP_OFF_PROT_LO, 32'h0100_0000, 32'h0100_0000);
         end else begin
            rd_chk(`FWP_OFF_PROT_LO, {13'h0, tab[i][37:19]}, 32'hFFFF_FFFF);
            rd_chk(`FWP_OFF_PROT_HI, {13'h0, tab[i][18:0]}, 32'hFFFF_FFFF);
         end
      end
      wr(8'h1C, 32'hFFFF_FFFF);
      rd_chk(8'h1C, 32'h0000_0000, 32'hFFFF_FFFF);
      wr_status(8'h01);
      wr(`FWP_OFF_CMD, {29'h0, `FWP_OP_WREN});
      wr(`FWP_OFF_PE_START, 32'h0006_0000);
      wr(`FWP_OFF_PE_END, 32'h0007_0000);
      rd_chk(`FWP_OFF_RESULT, 32'h0000_0008, 32'h0000_000C);
      check(u_array.ops, 32'h0000_0000, 32'hFFFF_FFFF);
      wr(`FWP_OFF_PE_END, 32'h0006_FFFF);
      rd_chk(`FWP_OFF_RESULT, 32'h0000_0004, 32'h0000_000C);
      check(u_array.ops, 32'h0000_0001, 32'hFFFF_FFFF);
      check({13'h0, u_array.last_end}, 32'h0006_FFFF, 32'hFFFF_FFFF);
      check({13'h0, u_array.last_start}, 32'h0006_0000, 32'hFFFF_FFFF);
      wr(`FWP_OFF_PE_END, 32'h0006_FFFF);
      rd_chk(`FWP_OFF_RESULT, 32'h0000_0008, 32'h0000_000C);
      check(u_array.ops, 32'h0000_0001, 32'hFFFF_FFFF);
      wr_status(8'h40);
      wr_status(8'h41);
      rd_chk(`FWP_OFF_STATUS, 32'h0000_0040, 32'h0000_00FF);
      wp_pin <= 1'b1;
      repeat (4) @(posedge clk_i);
      wr_status(8'h41);
      rd_chk(`FWP_OFF_STATUS, 32'h0000_0241, 32'h0000_03FF);
      wr_status(8'h80);
      wr_status(8'h81);
      rd_chk(`FWP_OFF_STATUS, 32'h0000_0080, 32'h0000_00FF);
      wr(`FWP_OFF_CMD, {29'h0, `FWP_OP_PWRCYC});
      rd_chk(`FWP_OFF_STATUS, 32'h0000_0000, 32'h0000_01FF);
      wr_status(8'hC0);
      wr_status(8'h00);
      wr(`FWP_OFF_CMD, {29'h0, `FWP_OP_PWRCYC});
      wr_status(8'h00);
      rd_chk(`FWP_OFF_STATUS, 32'h0000_00C0, 32'h0000_00FF);
      rd_chk(`FWP_OFF_RESULT, 32'h0000_0002, 32'h0000_0003);
      test_done();
   end
endmodule

`default_nettype wire
